// ==== core/tbd_cfg.svh ====
/*
  Constants of the terminal bus diagnostics block: register offsets,
  status bit positions, error codes and LED timing.
  Assumes inclusion by bare name from the package and the core module.
*/
`ifndef TBD_CFG_SVH
`define TBD_CFG_SVH
// ==========================================================
// Register map (byte addresses)
`define TBD_ADDR_W          8
`define TBD_OFS_STATUS      8'h00
`define TBD_OFS_CTRL        8'h04
`define TBD_OFS_EXP_LEN     8'h08
`define TBD_OFS_ERR_INFO    8'h0c
// ==========================================================
// Status word bits, bus reset control bit and length field width
`define TBD_ST_BUS_ERR      0
`define TBD_ST_CFG_CHG      1
`define TBD_ST_LEN_ERR      2
`define TBD_ST_NO_INPUTS    8
`define TBD_ST_IN_BUSY      9
`define TBD_ST_OUT_BUSY     10
`define TBD_ST_WATCHDOG     11
`define TBD_ST_ACYCLIC      15
`define TBD_CTRL_BUS_RST    0
`define TBD_LEN_W           12
// ==========================================================
// Blink codes
`define TBD_CODE_CMD        4'h3
`define TBD_CODE_BREAK      4'h4
`define TBD_CODE_REGCOM     4'h5
`define TBD_CODE_INTERNAL   4'h6
`define TBD_CODE_LEN        4'h7
`define TBD_ARG_INIT        8'h00
`define TBD_ARG_DATA_A      8'h01
`define TBD_ARG_DATA_B      8'h08
// ==========================================================
// Timing: clock, base tick, blink phases in ticks
`define TBD_CLK_NS          40
`define TBD_TICK_NS         1000000
`define TBD_TICK_CYC        (`TBD_TICK_NS / `TBD_CLK_NS)
`define TBD_FAST_HALF_MS    50
`define TBD_SLOW_HALF_MS    250
`define TBD_PAUSE_MS        1000
`define TBD_BUS_RST_NS      100000
`define TBD_BUS_RST_CYC     ((`TBD_BUS_RST_NS + `TBD_CLK_NS - 1) / `TBD_CLK_NS)
`endif

// ==== core/tbd_pkg.sv ====
/*
  Types of the terminal bus diagnostics block.
  Assumes tbd_cfg.svh on the include path.
*/
`include "tbd_cfg.svh"
package tbd_pkg;
  // Kind of fault reported by the bus engine
  typedef enum logic [2:0] {
    TBD_ERR_CMD, TBD_ERR_BREAK, TBD_ERR_REGCOM, TBD_ERR_INIT,
    TBD_ERR_DATA_A, TBD_ERR_DATA_B
  } tbd_err_kind_t;
  // One fault report from the bus engine
  typedef struct packed {
    tbd_err_kind_t kind;   // Fault class
    logic [7:0]    term;   // Physical slot of last working terminal
  } tbd_err_rpt_t;
  // Live bus conditions
  typedef struct packed {
    logic in_busy;         // Input update running
    logic out_busy;        // Output update running
    logic watchdog;        // Bus watchdog tripped
    logic in_done;         // Pulse: input update finished
    logic emc;             // Disturbance on the bus
    logic fieldbus_ok;     // Upstream fieldbus running
  } tbd_bus_cond_t;
  // Blink sequencer phases
  typedef enum {
    TBD_LED_IDLE, TBD_LED_FAST, TBD_LED_CODE, TBD_LED_PAUSE, TBD_LED_ARG,
    TBD_LED_GAP
  } tbd_led_st_t;
endpackage : tbd_pkg

// ==== core/tbd_diag.sv ====
/*
  Terminal bus diagnostics: status word, bus reset request, blink-coded
  red fault LED and green run LED.
  Assumes a bus engine that reports faults and conditions synchronously
  to sys_clk_i, and a register master with one-cycle strobes.
*/
// Notes on behaviour
// RULE_01: Status zero only when synchronous and error-free
// RULE_02: Busy bits may be nonzero without fault
// RULE_03: Bit 1 on configuration change since start
// RULE_04: Bit 2 on process image length mismatch
// RULE_05: Bit 8 until first valid inputs
// RULE_06: Bit 9 while input update runs
// RULE_07: Bit 10 while output update runs
// RULE_08: Bit 11 flags bus watchdog
// RULE_09: Bit 15 while bus reset in progress
// RULE_10: Reset request clears error, bus restarts
// RULE_11: Green LED only when fully fault-free
// RULE_12: Red LED uses fast and slow rates
// RULE_13: Fast burst, code, pause, argument, repeat
// RULE_14: Argument counts position of last terminal
// RULE_15: Passive terminals are not counted
// RULE_16: Disturbance gives plain continuous fast flashing
// RULE_17: Command failure shows code 3, argument 0
// RULE_18: Data break shows code 4, argument n
// RULE_19: Register failure shows code 5, argument n
// RULE_20: Code 6 with argument 0, 1, 8
// RULE_21: Length mismatch shows code 7, argument 0
// RULE_22: Internal errors keep LED until power-on; code 6 keeps only arguments 1 and 8, argument 0 clears on a bus reset
// RULE_23: Bit 0 sticky until bus reset succeeds
`timescale 1ns/100ps
`include "tbd_cfg.svh"
module tbd_diag #(
  parameter int MAX_TERM  = 64,              // Slots on the bus
  parameter int TICK_CYC  = `TBD_TICK_CYC,   // Clocks per 1 ms tick
  parameter int FAST_BURST = 4               // Fast blinks per start
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Register port
  input  wire logic [`TBD_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [31:0]             reg_rdata_o,
  // Bus engine side
  input  wire logic                    err_valid_i,
  input  wire tbd_pkg::tbd_err_rpt_t   err_rpt_i,
  input  wire tbd_pkg::tbd_bus_cond_t  cond_i,
  input  wire logic [MAX_TERM-1:0]     term_passive_i,
  input  wire logic [7:0]              cfg_sig_i,
  input  wire logic                    cfg_sig_vld_i,
  input  wire logic [`TBD_LEN_W-1:0]   act_len_i,
  output logic                         bus_reset_o,
  // LEDs
  output logic                         led_red_o,
  output logic                         led_green_o
);
  import tbd_pkg::*;

  // ==========================================================
  // Elaboration checks
  initial begin
    // Tick divider is 16 bits wide, blink counter 9 bits wide
    if (MAX_TERM < 1 || MAX_TERM > 255 || TICK_CYC < 1 || FAST_BURST < 1 ||
        TICK_CYC > 65536 || FAST_BURST > 256)
      $error("tbd_diag: unsupported parameter value");
  end

  localparam int FAST_T  = `TBD_FAST_HALF_MS;
  localparam int SLOW_T  = `TBD_SLOW_HALF_MS;
  localparam int PAUSE_T = `TBD_PAUSE_MS;
  localparam int RST_CYC = `TBD_BUS_RST_CYC;

  // ==========================================================
  // Helpers
  // Active terminals in slots 0..pos-1; passive slots are skipped
  function automatic logic [7:0] active_pos(input logic [7:0] pos,
                                            input logic [MAX_TERM-1:0] pas);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < MAX_TERM; i++) begin
      if (i < int'(pos) && !pas[i]) n = n + 8'h01;       // RULE_14 RULE_15
    end
    return n;
  endfunction : active_pos

  // ==========================================================
  // Error and status state
  logic                 err_r,     err_nxt;      // Sticky bus error
  logic [3:0]           code_r,    code_nxt;     // Blink code
  logic [7:0]           arg_r,     arg_nxt;      // Blink argument
  logic                 keep_r,    keep_nxt;     // Lasts until power-on
  logic                 noin_r,    noin_nxt;     // No valid inputs yet
  logic [7:0]           sig0_r,    sig0_nxt;     // Start-up config
  logic                 sig0v_r,   sig0v_nxt;    // Start-up config taken
  logic                 cfgc_r,    cfgc_nxt;     // Config has changed
  logic [`TBD_LEN_W-1:0] exp_len_r, exp_len_nxt; // Expected image length
  logic                 rst_act_r, rst_act_nxt;  // Bus reset running
  logic [11:0]          rst_cnt_r, rst_cnt_nxt;  // Bus reset timer
  logic                 rst_hit_r, rst_hit_nxt;  // Error seen during reset
  logic [31:0]          rdata_r,   rdata_nxt;    // Read data
  logic [15:0]          status;                  // Live status word
  logic                 len_err;                 // Length mismatch now
  logic                 rst_req;                 // Software asks reset

  assign len_err = (exp_len_r != act_len_i);                // RULE_04
  assign rst_req = reg_wr_i && reg_addr_i == `TBD_OFS_CTRL &&
                   reg_wdata_i[`TBD_CTRL_BUS_RST];

  // Status word; bits 9 and 10 may show without any fault
  always_comb begin
    status = 16'h0000;
    status[`TBD_ST_BUS_ERR]   = err_r;                      // RULE_23
    status[`TBD_ST_CFG_CHG]   = cfgc_r;                     // RULE_03
    status[`TBD_ST_LEN_ERR]   = len_err;                    // RULE_04
    status[`TBD_ST_NO_INPUTS] = noin_r;                     // RULE_05
    status[`TBD_ST_IN_BUSY]   = cond_i.in_busy;             // RULE_06 RULE_02
    status[`TBD_ST_OUT_BUSY]  = cond_i.out_busy;            // RULE_07 RULE_02
    status[`TBD_ST_WATCHDOG]  = cond_i.watchdog;            // RULE_08
    status[`TBD_ST_ACYCLIC]   = rst_act_r;                  // RULE_09 RULE_01
  end

  // Next state of error capture, bus reset and registers
  always_comb begin
    err_nxt     = err_r;
    code_nxt    = code_r;
    arg_nxt     = arg_r;
    keep_nxt    = keep_r;
    noin_nxt    = noin_r;
    sig0_nxt    = sig0_r;
    sig0v_nxt   = sig0v_r;
    cfgc_nxt    = cfgc_r;
    exp_len_nxt = exp_len_r;
    rst_act_nxt = rst_act_r;
    rst_cnt_nxt = rst_cnt_r;
    rst_hit_nxt = rst_hit_r;
    rdata_nxt   = 32'h0000_0000;
    if (cond_i.in_done) noin_nxt = 1'b0;                    // RULE_05
    // Bus reset: runs a fixed time, then clears if cause is gone
    if (rst_act_r) begin
      if (rst_cnt_r == 12'(RST_CYC - 1)) begin
        rst_act_nxt = 1'b0;
        if (!rst_hit_r && !err_valid_i && !len_err && !keep_r) begin
          err_nxt  = 1'b0;                                  // RULE_10 RULE_23
          code_nxt = 4'h0;
          arg_nxt  = 8'h00;
          cfgc_nxt = 1'b0;
          sig0v_nxt = 1'b0;
        end
      end else begin
        rst_cnt_nxt = rst_cnt_r + 12'h001;
      end
    end else if (rst_req) begin
      rst_act_nxt = 1'b1;                                   // RULE_09 RULE_10
      rst_cnt_nxt = 12'h000;
      rst_hit_nxt = 1'b0;
    end
    // First signature after reset is the start-up configuration;
    // placed after the clear so a change in the last cycle survives
    if (cfg_sig_vld_i) begin
      if (!sig0v_r) begin
        sig0_nxt  = cfg_sig_i;
        sig0v_nxt = 1'b1;
      end else if (cfg_sig_i != sig0_r) begin
        cfgc_nxt = 1'b1;                                    // RULE_03
      end
    end
    // Length mismatch raises code 7 unless a report is held
    if (len_err && !err_r) begin
      err_nxt  = 1'b1;                                      // RULE_21
      code_nxt = `TBD_CODE_LEN;
      arg_nxt  = 8'h00;
    end
    // A new report wins over a clear in the same cycle
    if (err_valid_i && !keep_r) begin
      err_nxt     = 1'b1;                                   // RULE_23
      rst_hit_nxt = rst_act_r;
      case (err_rpt_i.kind)
        TBD_ERR_CMD: begin
          code_nxt = `TBD_CODE_CMD;                         // RULE_17
          arg_nxt  = 8'h00;
        end
        TBD_ERR_BREAK: begin
          code_nxt = `TBD_CODE_BREAK;                       // RULE_18
          arg_nxt  = active_pos(err_rpt_i.term, term_passive_i);
        end
        TBD_ERR_REGCOM: begin
          code_nxt = `TBD_CODE_REGCOM;                      // RULE_19
          arg_nxt  = active_pos(err_rpt_i.term, term_passive_i);
        end
        TBD_ERR_INIT: begin
          code_nxt = `TBD_CODE_INTERNAL;                    // RULE_20
          arg_nxt  = `TBD_ARG_INIT;
        end
        TBD_ERR_DATA_A: begin
          code_nxt = `TBD_CODE_INTERNAL;                    // RULE_20
          arg_nxt  = `TBD_ARG_DATA_A;
          keep_nxt = 1'b1;                                  // RULE_22
        end
        TBD_ERR_DATA_B: begin
          code_nxt = `TBD_CODE_INTERNAL;                    // RULE_20
          arg_nxt  = `TBD_ARG_DATA_B;
          keep_nxt = 1'b1;                                  // RULE_22
        end
        default: begin
          code_nxt = code_r;
        end
      endcase
    end
    // Register writes
    if (reg_wr_i && reg_addr_i == `TBD_OFS_EXP_LEN)
      exp_len_nxt = reg_wdata_i[`TBD_LEN_W-1:0];
    // Register reads; unmapped addresses read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        `TBD_OFS_STATUS:   rdata_nxt = {16'h0000, status};
        `TBD_OFS_CTRL:     rdata_nxt = {31'h0, rst_act_r};
        `TBD_OFS_EXP_LEN:  rdata_nxt = {20'h00000, exp_len_r};
        `TBD_OFS_ERR_INFO: rdata_nxt = {15'h0000, keep_r, err_r,
                                        3'h0, code_r, arg_r};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register the error and status group
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_r     <= 1'b0;
      code_r    <= 4'h0;
      arg_r     <= 8'h00;
      keep_r    <= 1'b0;
      noin_r    <= 1'b1;
      sig0_r    <= 8'h00;
      sig0v_r   <= 1'b0;
      cfgc_r    <= 1'b0;
      exp_len_r <= '0;
      rst_act_r <= 1'b0;
      rst_cnt_r <= 12'h000;
      rst_hit_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      err_r     <= err_nxt;
      code_r    <= code_nxt;
      arg_r     <= arg_nxt;
      keep_r    <= keep_nxt;
      noin_r    <= noin_nxt;
      sig0_r    <= sig0_nxt;
      sig0v_r   <= sig0v_nxt;
      cfgc_r    <= cfgc_nxt;
      exp_len_r <= exp_len_nxt;
      rst_act_r <= rst_act_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      rst_hit_r <= rst_hit_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign bus_reset_o = rst_act_r;                           // RULE_10

  // ==========================================================
  // Blink sequencer
  // A 1 ms tick keeps the phase counters narrow
  logic [15:0]  div_r,  div_nxt;     // Tick divider
  logic         tick;                // One-cycle tick enable
  tbd_led_st_t  st_r,   st_nxt;      // Sequencer phase
  logic [9:0]   tm_r,   tm_nxt;      // Ticks left in half-period
  logic [8:0]   cnt_r,  cnt_nxt;     // Half-periods left in phase
  logic         red_r,  red_nxt;     // Red LED
  logic         grn_r,  grn_nxt;     // Green LED

  assign tick = (div_r == 16'(TICK_CYC - 1));

  // Load a phase of n blinks (two half-periods each)
  always_comb begin
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    st_nxt  = st_r;
    tm_nxt  = tm_r;
    cnt_nxt = cnt_r;
    red_nxt = red_r;
    // Green only with no fault, valid inputs and fieldbus up
    grn_nxt = !err_r && !cond_i.emc && !noin_r && !cond_i.watchdog &&
              cond_i.fieldbus_ok;                           // RULE_11
    if (cond_i.emc) begin
      // Plain fast flashing, no code
      st_nxt = TBD_LED_IDLE;                                // RULE_16
      if (tick) begin
        if (tm_r == 10'h000) begin
          tm_nxt  = 10'(FAST_T - 1);
          red_nxt = !red_r;
        end else begin
          tm_nxt = tm_r - 10'h001;
        end
      end
    end else if (tick) begin
      if (tm_r != 10'h000) begin
        tm_nxt = tm_r - 10'h001;
      end else begin
        case (st_r)
          TBD_LED_IDLE: begin
            red_nxt = 1'b0;
            if (err_r || keep_r) begin
              st_nxt  = TBD_LED_FAST;                       // RULE_13
              cnt_nxt = 9'(2 * FAST_BURST - 1);
              tm_nxt  = 10'(FAST_T - 1);
              red_nxt = 1'b1;
            end
          end
          TBD_LED_FAST, TBD_LED_CODE, TBD_LED_ARG: begin
            if (cnt_r != 9'h000) begin
              cnt_nxt = cnt_r - 9'h001;
              red_nxt = !red_r;
              tm_nxt  = (st_r == TBD_LED_FAST) ? 10'(FAST_T - 1)
                                               : 10'(SLOW_T - 1); // RULE_12
            end else if (st_r == TBD_LED_FAST) begin
              st_nxt  = TBD_LED_CODE;
              cnt_nxt = {code_r, 1'b0} - 9'h001;
              red_nxt = 1'b1;
              tm_nxt  = 10'(SLOW_T - 1);
            end else begin
              st_nxt  = (st_r == TBD_LED_CODE) ? TBD_LED_PAUSE
                                               : TBD_LED_GAP;
              red_nxt = 1'b0;                               // RULE_13
              tm_nxt  = 10'(PAUSE_T - 1);
            end
          end
          TBD_LED_PAUSE: begin
            // Argument zero shows no slow pulse at all
            if (arg_r == 8'h00) begin
              st_nxt = TBD_LED_GAP;
              tm_nxt = 10'(PAUSE_T - 1);
            end else begin
              st_nxt  = TBD_LED_ARG;                        // RULE_14
              cnt_nxt = {arg_r, 1'b0} - 9'h001;
              red_nxt = 1'b1;
              tm_nxt  = 10'(SLOW_T - 1);
            end
          end
          TBD_LED_GAP: begin
            st_nxt = TBD_LED_IDLE;                          // RULE_13
          end
          default: begin
            st_nxt = TBD_LED_IDLE;
          end
        endcase
      end
    end
  end

  // Register the sequencer group
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 16'h0000;
      st_r  <= TBD_LED_IDLE;
      tm_r  <= 10'h000;
      cnt_r <= 9'h000;
      red_r <= 1'b0;
      grn_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      st_r  <= st_nxt;
      tm_r  <= tm_nxt;
      cnt_r <= cnt_nxt;
      red_r <= red_nxt;
      grn_r <= grn_nxt;
    end
  end

  assign led_red_o   = red_r;
  assign led_green_o = grn_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_status_zero: assert property (                          // RULE_01
    ##1 (reg_rdata_o == 32'h0 && $past(reg_rd_i) &&
     $past(reg_addr_i) == `TBD_OFS_STATUS) |->
     $past(!err_r && !rst_act_r && !cond_i.in_busy && !cond_i.out_busy))
    else $error("zero status while busy or in error");
  a_busy_bit: assert property (                             // RULE_06
    reg_rd_i && reg_addr_i == `TBD_OFS_STATUS && cond_i.in_busy |=>
    reg_rdata_o[`TBD_ST_IN_BUSY])
    else $error("input busy bit missing");
  a_rst_len: assert property (                              // RULE_09
    $rose(rst_act_r) |-> rst_act_r [*8])
    else $error("bus reset ended too early");
  a_rst_start: assert property (                            // RULE_10
    rst_req && !rst_act_r |=> bus_reset_o)
    else $error("reset request not taken");
  a_err_sticky: assert property (                           // RULE_23
    err_r && !rst_act_r |=> err_r)
    else $error("error bit dropped without reset");
  a_keep_hold: assert property (                            // RULE_22
    keep_r |=> keep_r && err_r)
    else $error("persistent error cleared");
  a_code_cmd: assert property (                             // RULE_17
    err_valid_i && !keep_r && err_rpt_i.kind == TBD_ERR_CMD |=>
    code_r == `TBD_CODE_CMD && arg_r == 8'h00)
    else $error("command error code wrong");
  a_green_off: assert property (                            // RULE_11
    err_r |=> !led_green_o)
    else $error("green lit during error");
  a_code_start: assert property (                           // RULE_13
    st_r == TBD_LED_FAST && st_nxt == TBD_LED_CODE |=> led_red_o)
    else $error("code phase did not start lit");

  c_rst_ok: cover property ($fell(rst_act_r) && !err_r);
  c_break: cover property (st_r == TBD_LED_ARG && code_r == `TBD_CODE_BREAK);
  c_emc: cover property (cond_i.emc && $changed(led_red_o));

endmodule : tbd_diag

// ==== tb/tbd_term_model.sv ====
/*
  Behavioural model of the terminal chain behind the diagnostics block.
  Assumes the bench drives run, lvl, done, emc and fb after a clock edge.
*/
`timescale 1ns/100ps
module tbd_term_model (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Bus reset from the block
  input  wire logic              bus_reset_i,
  // Live conditions towards the block
  output tbd_pkg::tbd_bus_cond_t cond_o
);
  import tbd_pkg::*;
  // ==========================================================
  // Knobs set by the bench
  logic       run;  // Cyclic update traffic on
  logic [2:0] lvl;  // Held {input busy, output busy, watchdog}
  logic       done; // Extra input-finished pulse
  logic       emc;  // Disturbance on the bus
  logic       fb;   // Fieldbus up
  logic [2:0] cnt;  // Phase inside one update cycle
  wire  logic act = run && !bus_reset_i;
  // Traffic stops during a bus reset and restarts after it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 3'h0;
    end else begin
      cnt <= act ? cnt + 3'h1 : 3'h0;
    end
  end
  // Input phase, finish pulse, then output phase
  assign cond_o = '{in_busy: lvl[2] | (act && cnt < 3'h3),
                    out_busy: lvl[1] | (act && cnt[2] && !cnt[1]),
                    watchdog: lvl[0], in_done: done | (act && cnt == 3'h3),
                    emc: emc, fieldbus_ok: fb};
endmodule : tbd_term_model

// ==== tb/terminal_bus_diagnostics_test.sv ====
/*
  Self-checking bench for the terminal bus diagnostics block.
  Assumes tbd_pkg compiled first and tbd_cfg.svh on the include path.
*/
`timescale 1ns/100ps
`include "tbd_cfg.svh"
module terminal_bus_diagnostics_test;
  import tbd_pkg::*;
  // ==========================================================
  // Signals; tick shortened so blink phases stay short
  localparam int T = 4;
  localparam int NT = 16;
  localparam int FB = 4;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, err_valid_i, cfg_sig_vld_i;
  logic bus_reset_o, led_red_o, led_green_o;
  logic [7:0] reg_addr_i, cfg_sig_i, t;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [NT-1:0] term_passive_i;
  logic [11:0] act_len_i;
  tbd_err_rpt_t err_rpt_i;
  tbd_bus_cond_t cond_i;
  int fail_count, checks_done, hi, lo, n1, n2;
  int q[$];
  bit mon_on;
  tbd_err_kind_t ks[4] = '{TBD_ERR_CMD, TBD_ERR_BREAK, TBD_ERR_REGCOM,
                           TBD_ERR_INIT};
  tbd_diag #(.MAX_TERM(NT), .TICK_CYC(T), .FAST_BURST(FB)) dut (
    .sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .err_valid_i, .err_rpt_i, .cond_i, .term_passive_i,
    .cfg_sig_i, .cfg_sig_vld_i, .act_len_i, .bus_reset_o, .led_red_o,
    .led_green_o);
  tbd_term_model tm (.sys_clk_i, .rst_n_i, .bus_reset_i(bus_reset_o),
    .cond_o(cond_i));
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic por();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask : por
  task automatic fault(input tbd_err_kind_t k, input logic [7:0] tt);
    @(posedge sys_clk_i);
    err_rpt_i <= {k, tt};
    err_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    err_valid_i <= 1'b0;
  endtask : fault
  task automatic brst();
    int n;
    n = 0;
    wr(`TBD_OFS_CTRL, 32'h1);
    rd(`TBD_OFS_STATUS, d);
    chk("acyclic bit", d[15], 1'b1);
    while (bus_reset_o === 1'b1 && n < 3000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    chk("bus reset length", n + 2, `TBD_BUS_RST_CYC);
  endtask : brst
  // Expected error word: keep, error flag, code, argument
  function automatic logic [31:0] exp_info(tbd_err_kind_t k,
      logic [7:0] tt, logic [NT-1:0] p);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < NT; i++) if (i < tt && !p[i]) n++;
    case (k)
      TBD_ERR_CMD:    return {17'h1, 3'h0, `TBD_CODE_CMD, 8'h00};
      TBD_ERR_BREAK:  return {17'h1, 3'h0, `TBD_CODE_BREAK, n};
      TBD_ERR_REGCOM: return {17'h1, 3'h0, `TBD_CODE_REGCOM, n};
      TBD_ERR_INIT:   return {17'h1, 3'h0, `TBD_CODE_INTERNAL, 8'h00};
      TBD_ERR_DATA_A: return {17'h3, 3'h0, `TBD_CODE_INTERNAL, 8'h01};
      default:        return {17'h3, 3'h0, `TBD_CODE_INTERNAL, 8'h08};
    endcase
  endfunction : exp_info
  // Red LED pulses: 1 fast, 2 slow, 0 long dark gap
  always @(posedge sys_clk_i) begin
    if (mon_on && led_red_o === 1'b1) begin
      if (lo > 600 * T) q.push_back(0);
      lo = 0;
      hi++;
    end else if (mon_on) begin
      if (hi != 0) q.push_back(hi < 150 * T ? 1 : 2);
      hi = 0;
      lo++;
    end
  end
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #(40 * 90000);
    fail_count++;
    summarize();
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, err_valid_i, cfg_sig_vld_i} = 5'h0;
    {reg_addr_i, cfg_sig_i, reg_wdata_i, act_len_i} = '0;
    {term_passive_i, err_rpt_i, tm.run, tm.lvl, tm.done, tm.emc} = '0;
    tm.fb = 1'b0;
    void'($urandom(43));
    por();
    settle();
    rd(`TBD_OFS_STATUS, d);
    chk("status after reset", d, 32'h100);
    tm.done <= 1'b1;
    tm.fb <= 1'b1;
    @(posedge sys_clk_i);
    tm.done <= 1'b0;
    settle();
    chk("green run", led_green_o, 1'b1);
    rd(`TBD_OFS_STATUS, d);
    chk("status idle", d, 32'h0);
    for (int b = 0; b < 3; b++) begin
      tm.lvl <= 3'h4 >> b;
      settle();
      rd(`TBD_OFS_STATUS, d);
      chk("busy bits", d, 32'h200 << b);
    end
    chk("green on watchdog", led_green_o, 1'b0);
    tm.lvl <= 3'h0;
    tm.fb <= 1'b0;
    settle();
    chk("green no fieldbus", led_green_o, 1'b0);
    tm.fb <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cfg_sig_vld_i <= 1'b1;
      cfg_sig_i <= 8'h5a + i[7:0];
      @(posedge sys_clk_i);
    end
    cfg_sig_vld_i <= 1'b0;
    act_len_i <= 12'h005;
    settle();
    rd(`TBD_OFS_STATUS, d);
    chk("config and length", d & 32'h6, 32'h6);
    rd(`TBD_OFS_ERR_INFO, d);
    chk("length code", d[11:0], 12'h700);
    wr(`TBD_OFS_EXP_LEN, 32'h5);
    brst();
    settle();
    rd(`TBD_OFS_STATUS, d);
    chk("status after bus reset", d, 32'h0);
    foreach (ks[i]) begin
      t = 8'($urandom % 9);
      term_passive_i <= NT'($urandom);
      fault(ks[i], t);
      settle();
      rd(`TBD_OFS_ERR_INFO, d);
      chk("error info", d, exp_info(ks[i], t, term_passive_i));
      rd(`TBD_OFS_STATUS, d);
      chk("error bit", d[0], 1'b1);
      chk("green on error", led_green_o, 1'b0);
      brst();
      rd(`TBD_OFS_ERR_INFO, d);
      chk("error cleared", d, 32'h0);
    end
    term_passive_i <= 16'h0002;
    tm.run <= 1'b1;
    q.delete();
    mon_on = 1'b1;
    fault(TBD_ERR_REGCOM, 8'h04);
    repeat (52000) @(posedge sys_clk_i);
    mon_on = 1'b0;
    n1 = 0;
    // An older sequence may still run: start at a gap before a fast burst
    while (n1 + 1 < q.size() && !(q[n1] == 0 && q[n1 + 1] == 1)) n1++;
    n2 = n1 + 1;
    for (int k = 0; k < FB + 10; k++) begin
      chk("red pattern", n2 + k < q.size() ? q[n2 + k] : 9,
          k < FB ? 1 : (k == FB + 5 || k == FB + 9) ? 0 : 2);
    end
    tm.run <= 1'b0;
    brst();
    fault(TBD_ERR_DATA_A, 8'h00);
    brst();
    rd(`TBD_OFS_ERR_INFO, d);
    chk("persistent error", d, exp_info(TBD_ERR_DATA_A, 0, 0));
    por();
    fault(TBD_ERR_DATA_B, 8'h00);
    settle();
    rd(`TBD_OFS_ERR_INFO, d);
    chk("data error b", d, exp_info(TBD_ERR_DATA_B, 0, 0));
    por();
    tm.emc <= 1'b1;
    q.delete();
    mon_on = 1'b1;
    repeat (3000) @(posedge sys_clk_i);
    mon_on = 1'b0;
    n1 = 0;
    foreach (q[k]) n1 += (q[k] == 1) ? 1 : 100;
    chk("emc flashing", n1 > 4 && n1 < 100, 1'b1);
    summarize();
  end
endmodule : terminal_bus_diagnostics_test
